// *** le_sync_channel.sv ***
// One register transfer path from the bus domain into the peripheral domain
module le_sync_channel (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_load,
  input wire logic [le_sync_pkg::DATA_W-1:0] i_data,
  input wire logic i_edge,
  input wire logic i_hold,
  input wire logic [1:0] i_need,
  output logic [le_sync_pkg::DATA_W-1:0] o_value,
  output logic o_pending,
  output logic o_done
);
  logic [le_sync_pkg::DATA_W-1:0] staged;
  logic [1:0] edges;

  // Stage the write, count peripheral edges, then land the value
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      staged <= le_sync_pkg::REG_RESET;
      o_value <= le_sync_pkg::REG_RESET;
      o_pending <= 1'b0;
      edges <= 2'h0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_load) begin
        staged <= i_data; // A new write wins over a finishing one
        edges <= 2'h0;
        if (i_need == 2'h0) begin
          o_value <= i_data;
          o_pending <= 1'b0;
        end else begin
          o_pending <= 1'b1;
        end
      end else if (o_pending && i_edge && !i_hold) begin
        if (edges == i_need - 2'h1) begin
          o_value <= staged;
          o_pending <= 1'b0;
          o_done <= 1'b1;
        end else begin
          edges <= edges + 2'h1;
        end
      end
    end
  end
endmodule

// *** le_sync_device.sv ***
// Low-energy peripheral register block with delayed and immediate synchronisation
module le_sync_device (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_le_clk,
  input wire logic i_immediate,
  output logic [le_sync_pkg::NUM_DATA*le_sync_pkg::DATA_W-1:0] o_le_data,
  output logic [le_sync_pkg::DATA_W-1:0] o_le_cmd,
  output logic o_cmd_exec,
  output logic [le_sync_pkg::NUM_CHAN-1:0] o_pending,
  output logic o_update_hold_bit,
  output logic [le_sync_pkg::DATA_W-1:0] o_le_ticks,
  le_sync_if.dev_end bus
);
  logic sync1;
  logic sync2;
  logic sync3;
  logic le_rise;
  logic edge_near;
  logic mode_imm;
  logic hold_eff;
  logic stall;
  logic take;
  logic [le_sync_pkg::NUM_CHAN-1:0] load;
  logic [le_sync_pkg::NUM_CHAN-1:0] done;
  logic [le_sync_pkg::NUM_CHAN-1:0] pend;
  logic [le_sync_pkg::DATA_W-1:0] value [le_sync_pkg::NUM_CHAN];
  logic [le_sync_pkg::DATA_W-1:0] next_rdata;
  logic ack_pulse;
  logic [le_sync_pkg::DATA_W-1:0] read_word;
  logic mode_shown;

  // Peripheral clock pin passes three flops before use
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= i_le_clk;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Rising edge counted once while the second stage is high and the third still low
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      le_rise <= 1'b0;
    end else begin
      le_rise <= sync2 & ~sync3;
    end
  end

  // An edge is in flight while the two later stages differ
  assign edge_near = sync2 ^ sync3;

  // Mode level from logic on the same clock, held in a flop
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_imm <= 1'b0;
    end else begin
      mode_imm <= i_immediate;
    end
  end

  // Hold only bites in delayed mode
  assign hold_eff = o_update_hold_bit & ~mode_imm;

  // Immediate writes to the data and command registers that collide with an edge wait a cycle
  assign stall = mode_imm & bus.we & (bus.addr <= le_sync_pkg::IDX_CMD) & edge_near;
  assign take = bus.req & ~ack_pulse & ~stall;

  // One load strobe per synchronised register
  always_comb begin
    for (int i = 0; i < le_sync_pkg::NUM_CHAN; i++) begin
      load[i] = take & bus.we & (bus.addr == i[le_sync_pkg::IDX_W-1:0]);
    end
  end

  // Independent transfer path for each register
  genvar g;
  generate
    for (g = 0; g < le_sync_pkg::NUM_CHAN; g++) begin : chan
      logic [1:0] need;
      if (g < le_sync_pkg::NUM_DATA) begin : data_need
        assign need = mode_imm ? le_sync_pkg::IMM_DATA_EDGES : le_sync_pkg::DELAYED_EDGES;
      end else begin : cmd_need
        assign need = mode_imm ? le_sync_pkg::IMM_CMD_EDGES : le_sync_pkg::DELAYED_EDGES;
      end
      le_sync_channel u_chan (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_load(load[g]),
        .i_data(bus.wdata),
        .i_edge(le_rise),
        .i_hold(hold_eff),
        .i_need(need),
        .o_value(value[g]),
        .o_pending(pend[g]),
        .o_done(done[g])
      );
    end
  endgenerate

  // Peripheral-domain values seen by the peripheral logic
  always_comb begin
    for (int i = 0; i < le_sync_pkg::NUM_DATA; i++) begin
      o_le_data[i*le_sync_pkg::DATA_W +: le_sync_pkg::DATA_W] = value[i];
    end
  end
  assign o_le_cmd = value[le_sync_pkg::NUM_DATA];
  assign o_pending = pend;
  assign bus.pend = pend;

  // Command fires only when its transfer lands on an edge
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_cmd_exec <= 1'b0;
    end else begin
      o_cmd_exec <= done[le_sync_pkg::NUM_DATA];
    end
  end

  // Hold bit takes effect at the write itself
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_update_hold_bit <= le_sync_pkg::HOLD_RESET;
    end else if (take && bus.we && bus.addr == le_sync_pkg::IDX_HOLD) begin
      o_update_hold_bit <= bus.wdata[le_sync_pkg::HOLD_BIT];
    end
  end

  // Free count of peripheral edges, a peripheral-domain state
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_le_ticks <= le_sync_pkg::REG_RESET;
    end else if (le_rise) begin
      o_le_ticks <= o_le_ticks + 32'h0000_0001;
    end
  end

  // Data and command reads come from the peripheral-side copies only
  always_comb begin
    next_rdata = le_sync_pkg::REG_RESET;
    case (bus.addr)
      3'h0, 3'h1, 3'h2, 3'h3: next_rdata = value[bus.addr[1:0]];
      le_sync_pkg::IDX_HOLD: next_rdata[le_sync_pkg::HOLD_BIT] = o_update_hold_bit;
      le_sync_pkg::IDX_PEND: next_rdata[le_sync_pkg::NUM_CHAN-1:0] = pend;
      le_sync_pkg::IDX_TICKS: next_rdata = o_le_ticks;
      default: next_rdata = le_sync_pkg::REG_RESET;
    endcase
  end

  // Acknowledge each taken request for one cycle
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_pulse <= 1'b0;
    end else begin
      ack_pulse <= take;
    end
  end

  // Capture read data with the acknowledge
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      read_word <= le_sync_pkg::REG_RESET;
    end else if (take && !bus.we) begin
      read_word <= next_rdata;
    end
  end

  // Mode seen by the bridge
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_shown <= 1'b0;
    end else begin
      mode_shown <= mode_imm;
    end
  end

  assign bus.ack = ack_pulse;
  assign bus.rdata = read_word;
  assign bus.immediate = mode_shown;
endmodule

// *** le_sync_host.sv ***
// AXI4-Lite bridge that forwards software accesses to the low-energy block
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
module le_sync_host (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [le_sync_pkg::AXI_ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [le_sync_pkg::DATA_W-1:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [le_sync_pkg::AXI_ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [le_sync_pkg::DATA_W-1:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  le_sync_if.host_end link
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_WR = 5'b00010,
    S_RD = 5'b00100,
    S_BRESP = 5'b01000,
    S_RRESP = 5'b10000
  } state_t;

  state_t state;
  logic [le_sync_pkg::AXI_ADDR_W-1:0] aw_addr;
  logic [le_sync_pkg::AXI_ADDR_W-1:0] ar_addr;
  logic [le_sync_pkg::DATA_W-1:0] w_data;
  logic [3:0] w_strb;
  logic aw_got;
  logic w_got;
  logic ar_got;
  logic compat;
  logic [3:0] w_idx;
  logic [3:0] r_idx;
  logic w_dev;
  logic r_dev;
  logic guard;
  logic wr_go;

  assign w_idx = aw_addr[5:2];
  assign r_idx = ar_addr[5:2];
  assign w_dev = aw_addr[7:6] == 2'h0 && w_idx <= 4'h6;
  assign r_dev = ar_addr[7:6] == 2'h0 && r_idx <= 4'h6;
  // Hold off a rewrite of a register whose transfer is still pending, in delayed mode or with compat set
  assign guard = w_idx < 4'h4 && link.pend[w_idx[1:0]] && (compat || !link.immediate);
  assign wr_go = state == S_IDLE && aw_got && w_got;

  // Write address channel
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_addr <= 8'h00;
      aw_got <= 1'b0;
      o_awready <= 1'b1;
    end else if (i_awvalid && o_awready) begin
      aw_addr <= i_awaddr;
      aw_got <= 1'b1;
      o_awready <= 1'b0;
    end else if (state == S_BRESP && i_bready) begin
      aw_got <= 1'b0;
      o_awready <= 1'b1;
    end
  end

  // Write data channel
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      w_data <= le_sync_pkg::REG_RESET;
      w_strb <= 4'h0;
      w_got <= 1'b0;
      o_wready <= 1'b1;
    end else if (i_wvalid && o_wready) begin
      w_data <= i_wdata;
      w_strb <= i_wstrb;
      w_got <= 1'b1;
      o_wready <= 1'b0;
    end else if (state == S_BRESP && i_bready) begin
      w_got <= 1'b0;
      o_wready <= 1'b1;
    end
  end

  // Read address channel
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ar_addr <= 8'h00;
      ar_got <= 1'b0;
      o_arready <= 1'b1;
    end else if (i_arvalid && o_arready) begin
      ar_addr <= i_araddr;
      ar_got <= 1'b1;
      o_arready <= 1'b0;
    end else if (state == S_RRESP && i_rready) begin
      ar_got <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // Bridge control register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      compat <= le_sync_pkg::CTRL_RESET;
    end else if (wr_go && w_idx == le_sync_pkg::HOST_IDX_CTRL && aw_addr[7:6] == 2'h0 && w_strb[0]) begin
      compat <= w_data[le_sync_pkg::CTRL_COMPAT_BIT];
    end
  end

  // Sequencer: one access at a time, writes before reads
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= S_IDLE;
      link.req <= 1'b0;
      link.we <= 1'b0;
      link.addr <= 3'h0;
      link.wdata <= le_sync_pkg::REG_RESET;
      o_bvalid <= 1'b0;
      o_bresp <= le_sync_pkg::RESP_OKAY;
      o_rvalid <= 1'b0;
      o_rresp <= le_sync_pkg::RESP_OKAY;
      o_rdata <= le_sync_pkg::REG_RESET;
    end else begin
      case (state)
        S_IDLE: begin
          if (aw_got && w_got) begin
            if (w_dev && w_strb == le_sync_pkg::FULL_STRB) begin
              if (!guard) begin
                link.req <= 1'b1;
                link.we <= 1'b1;
                link.addr <= w_idx[2:0];
                link.wdata <= w_data;
                state <= S_WR;
              end
            end else begin
              o_bvalid <= 1'b1;
              o_bresp <= (aw_addr[7:6] == 2'h0 && (w_idx == le_sync_pkg::HOST_IDX_CTRL ||
                          w_idx == le_sync_pkg::HOST_IDX_STAT)) ? le_sync_pkg::RESP_OKAY
                          : le_sync_pkg::RESP_SLVERR;
              state <= S_BRESP;
            end
          end else if (ar_got) begin
            if (r_dev) begin
              link.req <= 1'b1;
              link.we <= 1'b0;
              link.addr <= r_idx[2:0];
              state <= S_RD;
            end else begin
              o_rvalid <= 1'b1;
              o_rresp <= le_sync_pkg::RESP_OKAY;
              o_rdata <= le_sync_pkg::REG_RESET;
              if (ar_addr[7:6] != 2'h0) begin
                o_rresp <= le_sync_pkg::RESP_SLVERR;
              end else if (r_idx == le_sync_pkg::HOST_IDX_CTRL) begin
                o_rdata[le_sync_pkg::CTRL_COMPAT_BIT] <= compat;
              end else if (r_idx == le_sync_pkg::HOST_IDX_STAT) begin
                o_rdata[4:0] <= {link.pend, link.immediate};
              end else begin
                o_rresp <= le_sync_pkg::RESP_SLVERR;
              end
              state <= S_RRESP;
            end
          end
        end
        S_WR: begin
          if (link.ack) begin
            link.req <= 1'b0;
            o_bvalid <= 1'b1;
            o_bresp <= le_sync_pkg::RESP_OKAY;
            state <= S_BRESP;
          end
        end
        S_RD: begin
          if (link.ack) begin
            link.req <= 1'b0;
            o_rdata <= link.rdata;
            o_rresp <= le_sync_pkg::RESP_OKAY;
            o_rvalid <= 1'b1;
            state <= S_RRESP;
          end
        end
        S_BRESP: begin
          if (i_bready) begin
            o_bvalid <= 1'b0;
            state <= S_IDLE;
          end
        end
        S_RRESP: begin
          if (i_rready) begin
            o_rvalid <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// *** le_sync_if.sv ***
// Link between the bus-side bridge and the low-energy register block
interface le_sync_if;
  logic req;
  logic we;
  logic [le_sync_pkg::IDX_W-1:0] addr;
  logic [le_sync_pkg::DATA_W-1:0] wdata;
  logic ack;
  logic [le_sync_pkg::DATA_W-1:0] rdata;
  logic [le_sync_pkg::NUM_CHAN-1:0] pend;
  logic immediate;
  modport host_end (output req, output we, output addr, output wdata,
                    input ack, input rdata, input pend, input immediate);
  modport dev_end (input req, input we, input addr, input wdata,
                   output ack, output rdata, output pend, output immediate);
endinterface

// *** le_sync_pkg.sv ***
// Package with constants for the low-energy register synchroniser
// Functional notes
// - Delayed write lands after three peripheral edges
// - Pending flag set on write, cleared when done
// - Master never rewrites a register while pending
// - Master need not wait for pending to clear
// - Immediate mode updates register during the access
// - Write near peripheral edge waits, adding wait-states
// - Immediate command runs at next edge, pending meanwhile
// - Immediate mode: other pending flags read zero
// - Reads always return synchronized peripheral data
// - Completion is judged from pending flags, not readback
// - Hold bit suspends transfers in delayed mode
// - Clearing hold starts all held transfers
// - Hold bit exists but inert in immediate mode
// - Compat option applies pending discipline to immediate mode
package le_sync_pkg;
  localparam int DATA_W = 32;
  localparam int IDX_W = 3;
  localparam int NUM_DATA = 3;
  localparam int NUM_CHAN = 4;
  // Register indices on the link (byte address on the bus is four times these)
  localparam logic [IDX_W-1:0] IDX_DATA0 = 3'h0;
  localparam logic [IDX_W-1:0] IDX_CMD = 3'h3;
  localparam logic [IDX_W-1:0] IDX_HOLD = 3'h4;
  localparam logic [IDX_W-1:0] IDX_PEND = 3'h5;
  localparam logic [IDX_W-1:0] IDX_TICKS = 3'h6;
  localparam int HOLD_BIT = 0;
  localparam logic HOLD_RESET = 1'b0;
  localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;
  // Peripheral edges needed per transfer
  localparam logic [1:0] DELAYED_EDGES = 2'h3;
  localparam logic [1:0] IMM_CMD_EDGES = 2'h1;
  localparam logic [1:0] IMM_DATA_EDGES = 2'h0;
  // Bus side
  localparam int AXI_ADDR_W = 8;
  localparam logic [3:0] HOST_IDX_CTRL = 4'h8;
  localparam logic [3:0] HOST_IDX_STAT = 4'h9;
  localparam int CTRL_COMPAT_BIT = 0;
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [3:0] FULL_STRB = 4'hf;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** le_sync_props.sv ***
// Link assertions for the low-energy register synchroniser
module le_sync_props (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic req,
  input wire logic we,
  input wire logic [le_sync_pkg::IDX_W-1:0] addr,
  input wire logic [le_sync_pkg::DATA_W-1:0] wdata,
  input wire logic ack,
  input wire logic [le_sync_pkg::NUM_CHAN-1:0] pend,
  input wire logic immediate
);
  timeunit 1ns;
  timeprecision 100ps;
  logic hold_seen;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // Hold bit as last written over the link
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hold_seen <= 1'b0;
    end else if (ack && we && addr == le_sync_pkg::IDX_HOLD) begin
      hold_seen <= wdata[le_sync_pkg::HOLD_BIT];
    end
  end
  a_delay_min_edges: assert property ($rose(pend[0]) && !immediate |-> pend[0] [*4])
    else $error("data0 pending cleared too early");
  a_take_sets_pend: assert property (ack && we && !immediate && addr <= le_sync_pkg::IDX_CMD |-> pend[addr])
    else $error("delayed write did not set pending");
  a_imm_stall_bound: assert property (immediate && req && we && !ack && addr < 3'h3 |-> ##[1:2] ack)
    else $error("immediate write stalled too long");
  a_imm_pend_zero: assert property (immediate |-> pend[2:0] == 3'h0)
    else $error("data pending set in immediate mode");
  a_hold_freezes: assert property (hold_seen && !ack && !immediate && pend[0] |=> pend[0])
    else $error("transfer finished while held");
  a_read_answer: assert property (req && !we && !ack |=> ack)
    else $error("read not answered next cycle");
  a_ack_single: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_pend_own_path: assert property ((pend & ~$past(pend)) != 4'h0 |->
    ack && we && (pend & ~$past(pend)) == (4'h1 << addr))
    else $error("pending set without own write");
endmodule

// *** low_energy_register_sync_bench.sv ***
// Testbench joining the bus bridge and the low-energy register block
module low_energy_register_sync_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic le_clk = 1'b0;
  logic imm = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic p1 = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, cmd_exec, hold_bit;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, le_cmd, ticks, t_set;
  logic [95:0] le_data;
  logic [3:0] pending;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_exec = 0;
  le_sync_if lnk ();
  le_sync_host i_le_sync_host (.i_clk(i_clk), .i_resetn(i_resetn), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .link(lnk));
  le_sync_device i_le_sync_device (.i_clk(i_clk), .i_resetn(i_resetn), .i_le_clk(le_clk), .i_immediate(imm),
    .o_le_data(le_data), .o_le_cmd(le_cmd), .o_cmd_exec(cmd_exec), .o_pending(pending),
    .o_update_hold_bit(hold_bit), .o_le_ticks(ticks), .bus(lnk));
  le_sync_props i_le_sync_props (.i_clk(i_clk), .i_resetn(i_resetn), .req(lnk.req), .we(lnk.we),
    .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack), .pend(lnk.pend), .immediate(lnk.immediate));
  // Bus clock and a free-running slow peripheral clock whose edges never meet a bus clock rise
  always #2 i_clk = ~i_clk;
  always #21.6 le_clk = ~le_clk;
  // Note ticks when data1 turns pending, and count command runs
  always @(negedge i_clk) begin
    if (pending[1] && !p1) t_set = ticks;
    p1 = pending[1];
    if (cmd_exec) n_exec++;
  end
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    @(posedge i_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    #1;
  endtask
  task automatic drain(input int k);
    repeat (400) if (pending[k]) @(posedge i_clk);
    #1;
    chk(pending[k], 1'b0);
  endtask
  task automatic t_basic();
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h14, d, r);
    chk(d, 32'h0);
    rd(8'h30, d, r);
    chk(r, le_sync_pkg::RESP_SLVERR);
    wr(8'h00, 32'h1234_5678, 4'h3, r);
    chk(r, le_sync_pkg::RESP_SLVERR);
    chk(pending, 4'h0);
  endtask
  task automatic t_delayed();
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h04, 32'hA5A5_0001, le_sync_pkg::FULL_STRB, r);
    chk(pending, 4'h2);
    rd(8'h04, d, r);
    chk(d, 32'h0);
    chk(le_data[63:32], 32'h0);
    drain(1);
    chk(ticks - t_set, 32'h3);
    chk(le_data, {32'h0, 32'hA5A5_0001, 32'h0});
    rd(8'h04, d, r);
    chk(d, 32'hA5A5_0001);
    // A rewrite while pending is held back until the first value has landed
    wr(8'h04, 32'h5A5A_0002, le_sync_pkg::FULL_STRB, r);
    wr(8'h04, 32'hA5A5_0001, le_sync_pkg::FULL_STRB, r);
    chk(le_data[63:32], 32'h5A5A_0002);
    chk(pending, 4'h2);
    drain(1);
    chk(le_data[63:32], 32'hA5A5_0001);
  endtask
  task automatic t_hold();
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h10, 32'h1, le_sync_pkg::FULL_STRB, r);
    chk(hold_bit, 1'b1);
    rd(8'h10, d, r);
    chk(d, 32'h1);
    wr(8'h00, 32'h1111_0000, le_sync_pkg::FULL_STRB, r);
    wr(8'h08, 32'h2222_0000, le_sync_pkg::FULL_STRB, r);
    repeat (60) @(posedge i_clk);
    rd(8'h14, d, r);
    chk(d, 32'h5);
    chk(le_data, {32'h0, 32'hA5A5_0001, 32'h0});
    wr(8'h10, 32'h0, le_sync_pkg::FULL_STRB, r);
    drain(0);
    drain(2);
    chk(le_data, {32'h2222_0000, 32'hA5A5_0001, 32'h1111_0000});
  endtask
  task automatic t_imm();
    logic [31:0] d;
    logic [1:0] r;
    int k;
    @(posedge i_clk);
    imm <= 1'b1;
    repeat (4) @(posedge i_clk);
    rd(8'h24, d, r);
    chk(d, 32'h1);
    wr(8'h10, 32'h1, le_sync_pkg::FULL_STRB, r);
    chk(hold_bit, 1'b1);
    // Back-to-back writes land in the access, some of them meeting an edge
    for (k = 0; k < 16; k++) begin
      wr(8'h08, 32'hC000_0000 + k, le_sync_pkg::FULL_STRB, r);
      chk(le_data[95:64], 32'hC000_0000 + k);
      chk(pending, 4'h0);
    end
    k = n_exec;
    wr(8'h0C, 32'hC3, le_sync_pkg::FULL_STRB, r);
    drain(3);
    repeat (2) @(posedge i_clk);
    #1;
    chk(n_exec - k, 1);
    chk(le_cmd, 32'hC3);
    wr(8'h20, 32'h1, le_sync_pkg::FULL_STRB, r);
    rd(8'h20, d, r);
    chk(d, 32'h1);
    wr(8'h0C, 32'hC4, le_sync_pkg::FULL_STRB, r);
    wr(8'h0C, 32'hC5, le_sync_pkg::FULL_STRB, r);
    chk(n_exec - k, 2);
    // The held-back command still runs once it has been passed on
    drain(3);
    repeat (2) @(posedge i_clk);
    #1;
    chk(n_exec - k, 3);
    chk(le_cmd, 32'hC5);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_basic();
    t_delayed();
    t_hold();
    t_imm();
    complete_run();
  end
  // Watchdog cuts a hang short
  initial begin
    #100000;
    n_mismatch++;
    complete_run();
  end
endmodule
